// ### include/aro_map.vh
/*
 Register map, field positions and reset values of the analog
 reference and op-amp control block.
 Assumes inclusion by bare name from design files.
*/
`ifndef ARO_MAP_VH
`define ARO_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ARO_OFF_VREF 4'h0
`define ARO_OFF_OPAMP 4'h4
`define ARO_OFF_CMP2 4'h8
`define ARO_OFF_STAT 4'hc

// ----------------------------------------
// Reference control fields
// ----------------------------------------
`define ARO_VREF_EN 7
`define ARO_VREF_OE1 6
`define ARO_VREF_OE2 5
`define ARO_VREF_RNG 4
`define ARO_VREF_LVL_HI 3
`define ARO_VREF_LVL_LO 0

// ----------------------------------------
// Amplifier and comparator fields
// ----------------------------------------
`define ARO_AMP_ONE 0
`define ARO_AMP_TWO 1
`define ARO_CMP2_NSEL 0

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ARO_ST_REF_ON 0
`define ARO_ST_GND 1
`define ARO_ST_AMP1 2
`define ARO_ST_AMP2 3
`define ARO_ST_SLEEP 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ARO_RST_VREF 8'h1f
`define ARO_RST_OPAMP 2'h0
`define ARO_RST_CMP2 1'h1

// ----------------------------------------
// Ladder ratio constants
// ----------------------------------------
`define ARO_LOW_DEN 6'h18
`define ARO_HIGH_DEN 6'h20
`define ARO_HIGH_BASE 6'h08

`endif

// ### src/aro_ctrl.v
/*
 Control logic for the comparator voltage reference and the two
 op amps, with a classic Wishbone register slave.
 Assumes a single core clock, pin direction latch bits from logic
 on the same clock, and analog switches fed by the outputs here.
*/
`include "aro_map.vh"
`timescale 1ns/1ps
`default_nettype none

module aro_ctrl #(
  parameter AW = 4
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire sys_rst,
  input wire clk_en,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Core status
  input wire sleep_mode,
  // Port direction latch bits, 1 = input
  input wire dir_ref_pin_one,
  input wire dir_ref_pin_two,
  input wire dir_amp_one_pin,
  input wire dir_amp_two_pin,
  // Reference ladder controls
  output reg ref_power_on,
  output reg ref_low_range_sel,
  output reg [3:0] ref_level_code,
  output reg [15:0] ref_tap_sel,
  output reg [5:0] ref_ratio_num,
  output reg [5:0] ref_ratio_den,
  output reg ref_ground_tie,
  // Reference pin switches
  output reg ref_pin1_drive,
  output reg ref_pin2_drive,
  output reg ref_pin1_port_oe,
  output reg ref_pin2_port_oe,
  // Comparator two input routing
  output reg cmp_two_neg_select,
  output reg cmp_two_neg_ref,
  // Op amps and their pins
  output reg amp_one_enable,
  output reg amp_two_enable,
  output reg amp_one_port_oe,
  output reg amp_two_port_oe
);

  // ----------------------------------------
  // Reset images of the derived outputs
  // ----------------------------------------
  // Register reset values
  localparam [7:0] RST_VREF = `ARO_RST_VREF;
  localparam [1:0] RST_OPAMP = `ARO_RST_OPAMP;
  localparam [0:0] RST_CMP2 = `ARO_RST_CMP2;

  // Outputs leave reset matching the registers they mirror
  localparam [3:0] RST_CODE = RST_VREF[`ARO_VREF_LVL_HI:`ARO_VREF_LVL_LO];
  localparam [0:0] RST_LOW = RST_VREF[`ARO_VREF_RNG];
  localparam [15:0] RST_TAP = 16'h0001 << RST_CODE;
  localparam [5:0] RST_NUM = RST_LOW ? {2'b00, RST_CODE} :
    (`ARO_HIGH_BASE + {2'b00, RST_CODE});
  localparam [5:0] RST_DEN = RST_LOW ? `ARO_LOW_DEN : `ARO_HIGH_DEN;
  localparam [0:0] RST_GND = ~RST_VREF[`ARO_VREF_EN] & RST_LOW & (RST_CODE == 4'h0);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [7:0] vref_q;
  reg [1:0] opamp_q;
  reg cmp2_q;
  reg [7:0] vref_d;
  reg [1:0] opamp_d;
  reg cmp2_d;
  reg ack_d;
  reg [31:0] rdat_d;
  wire req;
  wire wr_en;
  wire [3:0] adr;
  wire hit_vref;
  wire hit_opamp;
  wire hit_cmp2;
  wire hit_stat;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Address decode on the low byte-address bits
  assign adr = wb_adr_i[3:0];
  // Ack in the term keeps a held strobe from a new transfer in its ack cycle
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Only the low byte lane carries register bits
  assign wr_en = req & wb_we_i & wb_sel_i[0];
  assign hit_vref = (adr == `ARO_OFF_VREF);
  assign hit_opamp = (adr == `ARO_OFF_OPAMP);
  assign hit_cmp2 = (adr == `ARO_OFF_CMP2);
  assign hit_stat = (adr == `ARO_OFF_STAT);

  // ----------------------------------------
  // Derived analog controls
  // ----------------------------------------
  wire ref_en_w;
  wire oe1_w;
  wire oe2_w;
  wire low_w;
  wire [3:0] code_w;
  wire gnd_w;
  wire [5:0] num_w;
  wire [5:0] den_w;
  wire [15:0] tap_w;

  // Field extraction
  assign ref_en_w = vref_q[`ARO_VREF_EN];
  assign oe1_w = vref_q[`ARO_VREF_OE1];
  assign oe2_w = vref_q[`ARO_VREF_OE2];
  assign low_w = vref_q[`ARO_VREF_RNG];
  assign code_w = vref_q[`ARO_VREF_LVL_HI:`ARO_VREF_LVL_LO];

  // One-hot ladder tap, one of 16 per range
  assign tap_w = 16'h0001 << code_w;

  // Ratio of supply: low code/24, high (8+code)/32
  assign num_w = low_w ? {2'b00, code_w} : (`ARO_HIGH_BASE + {2'b00, code_w});
  assign den_w = low_w ? `ARO_LOW_DEN : `ARO_HIGH_DEN;

  // Ground tie when ladder off at code zero, low range
  assign gnd_w = ~ref_en_w & low_w & (code_w == 4'h0);

  // ----------------------------------------
  // Register write path
  // ----------------------------------------
  // Next register values from a bus write
  always @*
  begin
    vref_d = vref_q;
    opamp_d = opamp_q;
    cmp2_d = cmp2_q;
    if (wr_en)
    begin
      if (hit_vref)
      begin
        vref_d = wb_dat_i[7:0];
      end
      if (hit_opamp)
      begin
        opamp_d = wb_dat_i[1:0];
      end
      if (hit_cmp2)
      begin
        cmp2_d = wb_dat_i[`ARO_CMP2_NSEL];
      end
    end
  end

  // Register storage; sleep never clears the enables
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vref_q <= `ARO_RST_VREF;
      opamp_q <= `ARO_RST_OPAMP;
      cmp2_q <= `ARO_RST_CMP2;
    end
    else if (clk_en)
    begin
      vref_q <= vref_d;
      opamp_q <= opamp_d;
      cmp2_q <= cmp2_d;
    end
  end

  // ----------------------------------------
  // Register read path
  // ----------------------------------------
  // Read mux; unmapped offsets read zero
  always @*
  begin
    rdat_d = 32'h0000_0000;
    ack_d = req;
    if (hit_vref)
    begin
      rdat_d[7:0] = vref_q;
    end
    if (hit_opamp)
    begin
      rdat_d[1:0] = opamp_q;
    end
    if (hit_cmp2)
    begin
      rdat_d[`ARO_CMP2_NSEL] = cmp2_q;
    end
    if (hit_stat)
    begin
      rdat_d[`ARO_ST_REF_ON] = ref_power_on;
      rdat_d[`ARO_ST_GND] = ref_ground_tie;
      rdat_d[`ARO_ST_AMP1] = amp_one_enable;
      rdat_d[`ARO_ST_AMP2] = amp_two_enable;
      rdat_d[`ARO_ST_SLEEP] = sleep_mode;
    end
  end

  // Single-cycle acknowledge with registered data
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wb_ack_o <= ack_d;
      if (ack_d)
      begin
        wb_dat_o <= rdat_d;
      end
      else
      begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Reference ladder outputs
  // ----------------------------------------
  // Ladder power, range, tap and ratio
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Same image as a freshly reset control register
      ref_power_on <= RST_VREF[`ARO_VREF_EN];
      ref_low_range_sel <= RST_LOW;
      ref_level_code <= RST_CODE;
      ref_tap_sel <= RST_TAP;
      ref_ratio_num <= RST_NUM;
      ref_ratio_den <= RST_DEN;
      ref_ground_tie <= RST_GND;
    end
    else if (clk_en)
    begin
      ref_power_on <= ref_en_w;
      ref_low_range_sel <= low_w;
      ref_level_code <= code_w;
      ref_tap_sel <= tap_w;
      ref_ratio_num <= num_w;
      ref_ratio_den <= den_w;
      ref_ground_tie <= gnd_w;
    end
  end

  // ----------------------------------------
  // Reference pin switches
  // ----------------------------------------
  // Analog drive overrides the direction latch
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ref_pin1_drive <= RST_VREF[`ARO_VREF_OE1];
      ref_pin2_drive <= RST_VREF[`ARO_VREF_OE2];
      ref_pin1_port_oe <= 1'b0;
      ref_pin2_port_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_pin1_drive <= oe1_w;
      ref_pin2_drive <= oe2_w;
      // Port driver only for an output pin not taken by the ladder
      ref_pin1_port_oe <= ~oe1_w & ~dir_ref_pin_one;
      ref_pin2_port_oe <= ~oe2_w & ~dir_ref_pin_two;
    end
  end

  // ----------------------------------------
  // Comparator two routing
  // ----------------------------------------
  // Negative input: reference when select cleared
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmp_two_neg_select <= RST_CMP2;
      cmp_two_neg_ref <= ~RST_CMP2;
    end
    else if (clk_en)
    begin
      cmp_two_neg_select <= cmp2_q;
      cmp_two_neg_ref <= ~cmp2_q;
    end
  end

  // ----------------------------------------
  // Op amp enables and pin ownership
  // ----------------------------------------
  // Sleep is no input here, so the enables persist
  // Amp takes the pin; port driver released
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      amp_one_enable <= RST_OPAMP[`ARO_AMP_ONE];
      amp_two_enable <= RST_OPAMP[`ARO_AMP_TWO];
      amp_one_port_oe <= 1'b0;
      amp_two_port_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      amp_one_enable <= opamp_q[`ARO_AMP_ONE];
      amp_two_enable <= opamp_q[`ARO_AMP_TWO];
      amp_one_port_oe <= ~opamp_q[`ARO_AMP_ONE] & ~dir_amp_one_pin;
      amp_two_port_oe <= ~opamp_q[`ARO_AMP_TWO] & ~dir_amp_two_pin;
    end
  end

endmodule // aro_ctrl

`default_nettype wire

// ### verif/aro_ctrl_asserts.sv
/*
 Port checker for aro_ctrl.
 Assumes the bind below reaches every aro_ctrl instance.
*/
`timescale 1ns/1ps
`default_nettype none
module aro_ctrl_asserts #(
  parameter AW = 4
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  input wire clk_en,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Controls
  input wire ref_power_on,
  input wire ref_low_range_sel,
  input wire [3:0] ref_level_code,
  input wire [15:0] ref_tap_sel,
  input wire [5:0] ref_ratio_num,
  input wire [5:0] ref_ratio_den,
  input wire ref_ground_tie,
  input wire ref_pin1_drive,
  input wire ref_pin1_port_oe,
  input wire cmp_two_neg_select,
  input wire cmp_two_neg_ref,
  input wire amp_one_enable,
  input wire amp_one_port_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Handshake and register relations
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; wb_ack_o && clk_en |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_tap; ref_tap_sel == 16'h0001 << ref_level_code; endproperty
  a_tap: assert property (p_tap) else $error("tap not one-hot");
  property p_ratio; ref_ratio_den == (ref_low_range_sel ? 6'h18 : 6'h20) &&
    ref_ratio_num == (ref_low_range_sel ? 6'h00 : 6'h08) + ref_level_code; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_gnd; ref_ground_tie == (!ref_power_on && ref_low_range_sel && !ref_level_code);
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground tie wrong");
  property p_pin; ref_pin1_drive |-> !ref_pin1_port_oe; endproperty
  a_pin: assert property (p_pin) else $error("pin driver on");
  property p_amp; amp_one_enable |-> !amp_one_port_oe; endproperty
  a_amp: assert property (p_amp) else $error("amp pin driver on");
  property p_keep; $fell(amp_one_enable) |-> $past(wb_stb_i && wb_we_i); endproperty
  a_keep: assert property (p_keep) else $error("amp cleared alone");
  property p_rdz; wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |-> !wb_dat_o[31:2]; endproperty
  a_rdz: assert property (p_rdz) else $error("amp high bits set");
  property p_cmp; cmp_two_neg_ref == !cmp_two_neg_select; endproperty
  a_cmp: assert property (p_cmp) else $error("cmp route wrong");
endmodule // aro_ctrl_asserts
bind aro_ctrl aro_ctrl_asserts #(.AW(AW)) i_chk (.core_clk, .sys_rst, .clk_en, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ref_power_on, .ref_low_range_sel,
  .ref_level_code, .ref_tap_sel, .ref_ratio_num, .ref_ratio_den, .ref_ground_tie,
  .ref_pin1_drive, .ref_pin1_port_oe, .cmp_two_neg_select, .cmp_two_neg_ref,
  .amp_one_enable, .amp_one_port_oe);
`default_nettype wire

// ### verif/aro_ladder_model.sv
/*
 Ladder model: output level in VDD/96 steps.
 Assumes ladder controls from aro_ctrl; 8'hff means floating.
*/
`timescale 1ns/1ps
`default_nettype none
module aro_ladder_model (
  // Ladder controls
  input wire ref_power_on,
  input wire ref_low_range_sel,
  input wire [3:0] ref_level_code,
  input wire ref_ground_tie,
  // Level seen by the comparator
  output logic [7:0] lvl
);
  // Ground tie, then unpowered, else the two ranges
  always_comb
  begin
    if (ref_ground_tie) lvl = 8'h00;
    else if (!ref_power_on) lvl = 8'hff;
    else if (ref_low_range_sel) lvl = {2'h0, ref_level_code, 2'h0};
    else lvl = 8'h18 + 8'h03 * ref_level_code;
  end
endmodule // aro_ladder_model
`default_nettype wire

// ### verif/aro_ctrl_tb.sv
/*
 Register-level bench for aro_ctrl.
 Assumes the checker bind and the ladder model.
*/
`timescale 1ns/1ps
`default_nettype none
module aro_ctrl_tb;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic sleep_mode = 0, dir_ref_pin_one = 0, dir_ref_pin_two = 0, dir_amp_one_pin = 0;
  logic dir_amp_two_pin = 1, wb_ack_o, ref_power_on, ref_low_range_sel, ref_ground_tie;
  logic ref_pin1_drive, ref_pin2_drive, ref_pin1_port_oe, ref_pin2_port_oe;
  logic cmp_two_neg_select, cmp_two_neg_ref, amp_one_enable, amp_two_enable;
  logic amp_one_port_oe, amp_two_port_oe;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 0, ref_level_code;
  logic [5:0] ref_ratio_num, ref_ratio_den;
  logic [7:0] lvl;
  logic [15:0] ref_tap_sel;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic [7:0] vv [4] = '{8'hc5, 8'h30, 8'h9f, 8'h00};
  logic [7:0] lv [4] = '{8'h27, 8'h00, 8'h3c, 8'hff};
  int fails = 0, checks = 0;
  aro_ctrl i_dut (.*);
  aro_ladder_model i_lad (.ref_power_on, .ref_low_range_sel, .ref_level_code,
    .ref_ground_tie, .lvl);
  initial forever #10 core_clk = ~core_clk;
  // One bus cycle, held until ack
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, 24'h0, d, s};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    #1;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog far beyond the fewer than two hundred cycles the tests need
  initial
  begin
    #400000;
    fails++;
    summarize;
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 0;
    for (int r = 0; r < 2; r++)
    begin
      // Reset values and pin drivers
      bus(0, 4'h0, 0, 1);
      chk("vref", rd, 32'h0000_001f);
      bus(0, 4'h4, 0, 1);
      chk("amp", rd, 32'h0000_0000);
      bus(0, 4'h8, 0, 1);
      chk("cmp", rd, 32'h0000_0001);
      chk("oe", {ref_pin1_port_oe, ref_pin2_port_oe, amp_one_port_oe, amp_two_port_oe},
        4'he);
      // Reference settings through the ladder model
      for (int i = 0; i < 4; i++)
      begin
        bus(1, 4'h0, vv[i], 1);
        chk("ctl", {ref_power_on, ref_pin1_drive, ref_pin2_drive, ref_low_range_sel,
          ref_level_code}, vv[i]);
        chk("tap", ref_tap_sel, 16'h0001 << vv[i][3:0]);
        chk("rat", {ref_ratio_num, ref_ratio_den},
          vv[i][4] ? {2'h0, vv[i][3:0], 6'h18} : {6'h08 + vv[i][3:0], 6'h20});
        chk("tie", ref_ground_tie, !vv[i][7] && vv[i][4] && !vv[i][3:0]);
        chk("lvl", lvl, lv[i]);
        chk("poe", {ref_pin1_port_oe, ref_pin2_port_oe}, {~vv[i][6], ~vv[i][5]});
      end
      // Clock enable low freezes the pin drivers
      @(posedge core_clk) {clk_en, dir_ref_pin_one} <= 2'b01;
      repeat (3) @(posedge core_clk);
      #1 chk("hold", ref_pin1_port_oe, 1'b1);
      @(posedge core_clk) {clk_en, dir_ref_pin_one} <= 2'b11;
      repeat (2) @(posedge core_clk);
      #1 chk("dir", ref_pin1_port_oe, 1'b0);
      @(posedge core_clk) dir_ref_pin_one <= 0;
      // Op amp enables and unused bits
      bus(1, 4'h4, 8'hff, 1);
      chk("ena", {amp_two_enable, amp_one_enable}, 2'h3);
      chk("aoe", {amp_one_port_oe, amp_two_port_oe}, 2'h0);
      bus(0, 4'h4, 0, 1);
      chk("amp", rd, 32'h0000_0003);
      // Sleep leaves the enables alone
      @(posedge core_clk) sleep_mode <= 1;
      repeat (5) @(posedge core_clk);
      bus(0, 4'hc, 0, 1);
      chk("stat", rd, 32'h0000_001c);
      @(posedge core_clk) sleep_mode <= 0;
      // A write without the low lane is dropped
      bus(1, 4'h4, 8'h01, 4'he);
      chk("sel", {amp_two_enable, amp_one_enable}, 2'h3);
      bus(1, 4'h4, 8'h02, 1);
      chk("ena", {amp_two_enable, amp_one_enable}, 2'h2);
      bus(0, 4'h2, 0, 1);
      chk("unmapped", rd, 32'h0000_0000);
      bus(1, 4'h8, 8'h00, 1);
      chk("route", {cmp_two_neg_select, cmp_two_neg_ref}, 2'h1);
      // Reset again in mid-run
      @(posedge core_clk) sys_rst <= 1;
      @(posedge core_clk) sys_rst <= 0;
    end
    summarize;
  end
endmodule // aro_ctrl_tb
`default_nettype wire
